// ===== src/csd_decoder.sv
// Memory chip-select decoder with its four control registers.
// Summary of operation
// - Select on any in-range access, CPU or DMA.
// - Six selects: top, bottom, four mid quarters.
// - Sizes 2K-128K; top/bottom also 1K, 256K.
// - Top select when address at or above limit.
// - Top area 1K after reset, usable at once.
// - Bottom select when address at or below limit.
// - Bottom select idle until its register accessed.
// - Low bits give top and bottom ready modes.
// - One-hot size field sets mid block size.
// - Mid block split in four ascending quarters.
// - Base bits give address bits 19 to 13.
// - Mid selects idle until both registers accessed.
// - Base low bits give common mid ready mode.
// - Enhanced mode leaves only mid quarter two.
// - Ready top bit ignores external ready.
// - Programmed and external waits overlap.
// - All selects high during reset.
`timescale 1ns/100ps
`default_nettype none
`include "csd_params.svh"
module csd_decoder (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rst_n,
	input  wire csd_pkg::csd_cycle_t   i_cyc,
	input  wire csd_pkg::csd_reg_req_t i_reg,
	input  wire logic                  i_enhanced,
	input  wire logic                  i_ext_ready,
	output logic [15:0]                o_reg_rdata,
	output logic                       o_top_area_select_n,
	output logic                       o_bottom_area_select_n,
	output logic                       o_mid_quarter0_select_n,
	output logic                       o_mid_quarter1_select_n,
	output logic                       o_mid_quarter2_select_n,
	output logic                       o_mid_quarter3_select_n,
	output csd_pkg::csd_ready_mode_t   o_ready_mode,
	output logic                       o_cycle_ready
);
	import csd_pkg::*;

	// ****************************************************************
	// Register file.
	// ****************************************************************
	logic [15:0] upper_q;
	logic [15:0] lower_q;
	logic [15:0] mbase_q;
	logic [15:0] msize_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        lower_seen;
	logic        mbase_seen;
	logic        msize_seen;

	wire acc       = i_reg.rd || i_reg.wr;
	wire hit_upper = (i_reg.addr == `CSD_OFF_UPPER);
	wire hit_lower = (i_reg.addr == `CSD_OFF_LOWER);
	wire hit_mbase = (i_reg.addr == `CSD_OFF_MBASE);
	wire hit_msize = (i_reg.addr == `CSD_OFF_MSIZE);

	// Top limit comes out of reset as a 1K area.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			upper_q <= `CSD_UPPER_RESET;
		end else if (i_reg.wr && hit_upper) begin
			upper_q <= i_reg.wdata;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			lower_q <= 16'h0000;
			mbase_q <= 16'h0000;
			msize_q <= 16'h0000;
		end else begin
			lower_q <= (i_reg.wr && hit_lower) ? i_reg.wdata : lower_q;
			mbase_q <= (i_reg.wr && hit_mbase) ? i_reg.wdata : mbase_q;
			msize_q <= (i_reg.wr && hit_msize) ? i_reg.wdata : msize_q;
		end
	end

	assign rdata_d = !i_reg.rd ? rdata_q :
			hit_upper ? upper_q :
			hit_lower ? lower_q :
			hit_mbase ? mbase_q :
			hit_msize ? msize_q : 16'h0000;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Reads and writes both mark a register as touched.
	csd_seen_flag u_seen_lower (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_touch   (acc && hit_lower),
		.o_seen    (lower_seen)
	);
	csd_seen_flag u_seen_mbase (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_touch   (acc && hit_mbase),
		.o_seen    (mbase_seen)
	);
	csd_seen_flag u_seen_msize (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_touch   (acc && hit_msize),
		.o_seen    (msize_seen)
	);

	// ****************************************************************
	// Address decode.
	// ****************************************************************
	logic [3:0]  msize_idx;
	logic [6:0]  msize_oh;
	logic [6:0]  mid_mask;
	logic [1:0]  quarter;
	logic [3:0]  mid_hit;
	logic [15:0] a_hi;
	logic [15:0] upper_lim;
	logic [15:0] lower_lim;

	assign a_hi      = i_cyc.addr[19:4];
	// Limits compare in 1K steps, so 1K to 256K fit.
	assign upper_lim = {upper_q[15:`CSD_LIMIT_LSB], `CSD_LOW_ZEROS};
	assign lower_lim = {lower_q[15:`CSD_LIMIT_LSB], `CSD_LOW_ONES};
	assign msize_oh  = msize_q[`CSD_MSIZE_MSB:`CSD_MSIZE_LSB];

	// Only the address and the memory flag matter, not which master drives it.
	wire mem_cyc = i_cyc.valid && i_cyc.mem;

	// Top area runs from the limit to the end of memory.
	wire top_hit = mem_cyc && (a_hi >= upper_lim);
	// Bottom area runs from zero to the limit.
	// Bottom select waits for its first register access.
	wire bot_hit = mem_cyc && lower_seen && (a_hi <= lower_lim);

	// Find the set size bit; block spans 8K shifted by it.
	always_comb begin
		msize_idx = 4'h0;
		for (int k = 0; k < 7; k++) begin
			if (msize_oh[k]) begin
				msize_idx = 4'(k);
			end
		end
	end

	assign mid_mask = ~(msize_oh - 7'h01);
	// Base bits align with address bits 19 to 13.
	wire mid_in = ((i_cyc.addr[19:13] & mid_mask) ==
			(mbase_q[15:`CSD_MBASE_LSB] & mid_mask));
	// The two bits just under the block size pick the quarter.
	wire [8:0] shifted = i_cyc.addr[19:11] >> msize_idx;
	assign quarter = shifted[1:0];
	// Mid selects wait for both registers to be touched.
	wire mid_on = mem_cyc && mid_in && mbase_seen && msize_seen;

	// Enhanced mode keeps only quarter two.
	always_comb begin
		for (int q = 0; q < 4; q++) begin
			mid_hit[q] = mid_on && (quarter == 2'(q)) && (!i_enhanced || q == 2);
		end
	end

	// Top and bottom modes, common mid mode.
	wire [2:0] mode_d = top_hit ? upper_q[2:0] :
			bot_hit ? lower_q[2:0] :
			mid_on ? mbase_q[2:0] : 3'h0;

	// ****************************************************************
	// Select outputs.
	// ****************************************************************
	logic [5:0] sel_n_q;
	logic [2:0] mode_q;
	wire  [5:0] sel_n_d = ~{mid_hit, bot_hit, top_hit};

	// Selects follow the cycle address for its whole length.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sel_n_q <= `CSD_SEL_IDLE;
			mode_q  <= 3'h0;
		end else begin
			sel_n_q <= sel_n_d;
			mode_q  <= mode_d;
		end
	end

	assign o_top_area_select_n     = sel_n_q[0];
	assign o_bottom_area_select_n  = sel_n_q[1];
	assign o_mid_quarter0_select_n = sel_n_q[2];
	assign o_mid_quarter1_select_n = sel_n_q[3];
	assign o_mid_quarter2_select_n = sel_n_q[4];
	assign o_mid_quarter3_select_n = sel_n_q[5];
	assign o_ready_mode            = mode_q;
	assign o_reg_rdata             = rdata_q;

	// ****************************************************************
	// Ready generation.
	// ****************************************************************
	logic rdy_s1_q;
	logic rdy_s2_q;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
		end else begin
			rdy_s1_q <= i_ext_ready;
			rdy_s2_q <= rdy_s1_q;
		end
	end

	// Cycle ready merges counted waits with external ready.
	csd_wait_gen u_wait (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_start   (i_cyc.start),
		.i_valid   (i_cyc.valid),
		.i_mode    (mode_d),
		.i_ext_rdy (rdy_s2_q),
		.o_ready   (o_cycle_ready)
	);

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	a_reset_idle: assert property ($past(!i_rst_n) |-> sel_n_q == `CSD_SEL_IDLE
			&& mode_q == 3'h0)
		else $error("select or ready mode active right after reset");
	a_upper_init: assert property ($past(!i_rst_n) |-> upper_q == 16'hFFFB)
		else $error("top limit wrong after reset");
	a_top_decode: assert property (mem_cyc && a_hi >= upper_lim |=> !o_top_area_select_n)
		else $error("top select missing in top area");
	a_bottom_decode: assert property (mem_cyc && lower_seen && a_hi <= lower_lim
			|=> !o_bottom_area_select_n)
		else $error("bottom select missing in bottom area");
	a_bottom_gate: assert property (!lower_seen |=> o_bottom_area_select_n)
		else $error("bottom select before register access");
	a_mid_gate: assert property (!(mbase_seen && msize_seen)
			|=> &sel_n_q[5:2])
		else $error("mid select before both registers accessed");
	a_mid_single: assert property ($onehot0(~sel_n_q[5:2]))
		else $error("more than one mid quarter selected");
	a_enh_quarters: assert property (i_enhanced |=> sel_n_q[2] && sel_n_q[3]
			&& sel_n_q[5])
		else $error("unused mid quarter driven in enhanced mode");
	a_top_mode: assert property (top_hit |=> o_ready_mode == $past(upper_q[2:0]))
		else $error("top ready mode not presented");
	a_seen_set: assert property (i_reg.rd && hit_lower |=> lower_seen)
		else $error("read did not mark bottom register touched");

	// ****************************************************************
	// Decode, ready-mode and touched-flag checks.
	// ****************************************************************
	a_idle_nonmem: assert property (!mem_cyc |=> sel_n_q == `CSD_SEL_IDLE)
		else $error("select driven outside a memory cycle");
	a_top_off: assert property (!(mem_cyc && a_hi >= upper_lim)
			|=> o_top_area_select_n)
		else $error("top select driven below the top area");
	a_bottom_off: assert property (!(mem_cyc && lower_seen && a_hi <= lower_lim)
			|=> o_bottom_area_select_n)
		else $error("bottom select driven above the bottom area");
	a_mid_count: assert property (mid_on && !i_enhanced
			|=> $countones(~sel_n_q[5:2]) == 1)
		else $error("mid block hit without exactly one quarter selected");
	a_mid_off: assert property (!mid_on |=> &sel_n_q[5:2])
		else $error("mid select driven outside the mid block");
	a_mid_low: assert property (mid_on && quarter == 2'h0 && !i_enhanced
			|=> !o_mid_quarter0_select_n)
		else $error("lowest mid quarter not selected");
	a_mid_high: assert property (mid_on && quarter == 2'h3 && !i_enhanced
			|=> !o_mid_quarter3_select_n)
		else $error("highest mid quarter not selected");
	a_quarter_two: assert property (mid_on && quarter == 2'h2
			|=> !o_mid_quarter2_select_n)
		else $error("mid quarter two not selected");
	a_bottom_mode: assert property (bot_hit && !top_hit
			|=> o_ready_mode == $past(lower_q[2:0]))
		else $error("bottom ready mode not presented");
	a_mid_mode: assert property (mid_on && !top_hit && !bot_hit
			|=> o_ready_mode == $past(mbase_q[2:0]))
		else $error("mid ready mode not presented");
	a_mode_none: assert property (!mem_cyc |=> o_ready_mode == 3'h0)
		else $error("ready mode presented outside a memory cycle");
	a_base_seen: assert property (acc && hit_mbase |=> mbase_seen)
		else $error("access did not mark mid base register touched");
	a_size_seen: assert property (acc && hit_msize |=> msize_seen)
		else $error("access did not mark mid size register touched");
endmodule
`default_nettype wire

// ===== src/csd_params.svh
// Constants of the memory chip-select decoder.
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH
`define CSD_OFF_UPPER     8'hA0
`define CSD_OFF_LOWER     8'hA2
`define CSD_OFF_MBASE     8'hA6
`define CSD_OFF_MSIZE     8'hA8
`define CSD_UPPER_RESET   16'hFFFB
`define CSD_LIMIT_LSB     6
`define CSD_LOW_ONES      6'h3F
`define CSD_LOW_ZEROS     6'h00
`define CSD_MSIZE_LSB     8
`define CSD_MSIZE_MSB     14
`define CSD_MBASE_LSB     9
`define CSD_RDY_IGNORE    2
`define CSD_SEL_IDLE      6'h3F
`define CSD_NO_WAITS      2'h0
`endif

// ===== src/csd_pkg.sv
// Types shared by the memory chip-select decoder files.
package csd_pkg;
	typedef struct packed {
		logic        valid;
		logic        start;
		logic        mem;
		logic [19:0] addr;
	} csd_cycle_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} csd_reg_req_t;

	typedef logic [2:0] csd_ready_mode_t;
endpackage

// ===== src/csd_seen_flag.sv
// Access-seen flag for a register that is inactive until first touched.
`timescale 1ns/100ps
`default_nettype none
module csd_seen_flag (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	input  wire logic i_touch,
	output logic      o_seen
);
	logic seen_q;

	// Cleared by reset, set by access.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			seen_q <= 1'b0;
		end else if (i_touch) begin
			seen_q <= 1'b1;
		end
	end

	assign o_seen = seen_q;
endmodule
`default_nettype wire

// ===== src/csd_wait_gen.sv
// Wait-state counter that runs in parallel with external ready.
`timescale 1ns/100ps
`default_nettype none
`include "csd_params.svh"
module csd_wait_gen (
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_start,
	input  wire logic                     i_valid,
	input  wire csd_pkg::csd_ready_mode_t i_mode,
	input  wire logic                     i_ext_rdy,
	output logic                          o_ready
);
	import csd_pkg::*;

	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic       ign_q;
	logic       busy_q;
	logic       rdy_q;
	wire        cnt_zero = (cnt_q == `CSD_NO_WAITS);

	assign cnt_d = i_start ? i_mode[1:0] : (cnt_zero ? cnt_q : cnt_q - 2'h1);

	// Count programmed waits, ignore or honour ready.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			cnt_q  <= `CSD_NO_WAITS;
			ign_q  <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			ign_q  <= i_start ? i_mode[`CSD_RDY_IGNORE] : ign_q;
			busy_q <= i_valid;
		end
	end

	// Ready needs both unless the ignore bit is set, so the longer wait wins.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= busy_q && i_valid && !i_start && cnt_zero && (ign_q || i_ext_rdy);
		end
	end

	assign o_ready = rdy_q;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	a_wait_ignore: assert property (busy_q && i_valid && !i_start && cnt_zero && ign_q
			|=> o_ready)
		else $error("ready missing with waits done and external ready ignored");
	a_wait_start: assert property (i_start |=> !o_ready)
		else $error("ready given in the first cycle of a transfer");
	a_wait_ext: assert property (!ign_q && !i_ext_rdy |=> !o_ready)
		else $error("ready given while external ready still low");
endmodule
`default_nettype wire

// ===== tb/csd_decoder_bench.sv
// Self-checking bench of the memory chip-select decoder.
`timescale 1ns/100ps
`default_nettype none
`include "csd_params.svh"
module csd_decoder_bench;
	import csd_pkg::*;
	typedef struct packed {
		logic [19:0] a;
		logic        m;
		logic [5:0]  s;
		logic [2:0]  r;
	} csd_row_t;
	localparam csd_row_t ROWS [11] = '{
		'{20'hF_F000, 1'b1, 6'h1F, 3'h6}, '{20'hF_EFFF, 1'b1, 6'h3F, 3'h0},
		'{20'h0_07FF, 1'b1, 6'h2F, 3'h4}, '{20'h0_0800, 1'b1, 6'h3F, 3'h0},
		'{20'h1_0000, 1'b1, 6'h37, 3'h5}, '{20'h1_1FFF, 1'b1, 6'h37, 3'h5},
		'{20'h1_2000, 1'b1, 6'h3B, 3'h5}, '{20'h1_4000, 1'b1, 6'h3D, 3'h5},
		'{20'h1_7FFF, 1'b1, 6'h3E, 3'h5}, '{20'h1_8000, 1'b1, 6'h3F, 3'h0},
		'{20'h1_0000, 1'b0, 6'h3F, 3'h0}};
	logic            i_clk_sys = 1'b0;
	logic            i_rst_n   = 1'b0;
	csd_cycle_t      i_cyc     = '0;
	csd_reg_req_t    i_reg     = '0;
	logic            i_enhanced = 1'b0;
	logic            ext_rdy;
	logic [3:0]      slow      = 4'h0;
	logic [15:0]     o_reg_rdata;
	logic [5:0]      sel;
	csd_ready_mode_t o_ready_mode;
	logic            o_cycle_ready;
	int              fails     = 0;
	int              n_tests   = 0;
	int              last_n;
	csd_decoder i_csd_decoder (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cyc(i_cyc),
		.i_reg(i_reg), .i_enhanced(i_enhanced), .i_ext_ready(ext_rdy),
		.o_reg_rdata(o_reg_rdata), .o_top_area_select_n(sel[5]),
		.o_bottom_area_select_n(sel[4]), .o_mid_quarter0_select_n(sel[3]),
		.o_mid_quarter1_select_n(sel[2]), .o_mid_quarter2_select_n(sel[1]),
		.o_mid_quarter3_select_n(sel[0]), .o_ready_mode(o_ready_mode),
		.o_cycle_ready(o_cycle_ready));
	csd_mem_model i_csd_mem_model (.i_clk_sys(i_clk_sys), .i_sel_n(sel), .i_slow(slow),
		.o_ready(ext_rdy));
	initial begin
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_reg = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge i_clk_sys) #1;
		i_reg.wr = 1'b0;
		@(posedge i_clk_sys) #1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		i_reg = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(posedge i_clk_sys) #1;
		i_reg.rd = 1'b0;
		@(posedge i_clk_sys) #1;
		chk("rdata", e, o_reg_rdata);
	endtask
	task automatic cyc(input logic [19:0] a, input logic m, input logic [5:0] es,
			input logic [2:0] er, input int en);
		int n;
		n = 0;
		i_cyc = '{valid: 1'b1, start: 1'b1, mem: m, addr: a};
		@(posedge i_clk_sys) #1;
		i_cyc.start = 1'b0;
		do begin
			@(posedge i_clk_sys) #1;
			n++;
			if (n == 1) begin
				chk("sel", 16'(es), 16'(sel));
				chk("mode", 16'(er), 16'(o_ready_mode));
			end
		end while (o_cycle_ready !== 1'b1 && n < 20);
		last_n = n;
		if (en != 0) begin
			chk("waits", 16'(en), 16'(n));
		end
		i_cyc.valid = 1'b0;
		repeat (2) @(posedge i_clk_sys) #1;
	endtask
	initial begin
		#1_000_000;
		fails++;
		test_done();
	end
	initial begin
		i_cyc = '{valid: 1'b1, start: 1'b0, mem: 1'b1, addr: 20'hF_FC00};
		repeat (10) begin
			@(posedge i_clk_sys) #1;
			chk("sel", 16'h003F, 16'(sel));
		end
		i_cyc.valid = 1'b0;
		i_rst_n = 1'b1;
		@(posedge i_clk_sys) #1;
		cyc(20'hF_FC00, 1'b1, 6'h1F, 3'h3, 4);
		cyc(20'hF_FBFF, 1'b1, 6'h3F, 3'h0, 1);
		cyc(20'h0_0000, 1'b1, 6'h3F, 3'h0, 1);
		rd(`CSD_OFF_UPPER, 16'hFFFB);
		// Legal encodings only, aligned and non-overlapping.
		wr(`CSD_OFF_MBASE, 16'h1005);
		cyc(20'h1_0000, 1'b1, 6'h3F, 3'h0, 1);
		wr(`CSD_OFF_MSIZE, 16'h0400);
		wr(`CSD_OFF_LOWER, 16'h007C);
		wr(`CSD_OFF_UPPER, 16'hFF3E);
		rd(`CSD_OFF_LOWER, 16'h007C);
		rd(`CSD_OFF_MSIZE, 16'h0400);
		wr(8'hA4, 16'h1234);
		rd(8'hA4, 16'h0000);
		foreach (ROWS[i]) begin
			cyc(ROWS[i].a, ROWS[i].m, ROWS[i].s, ROWS[i].r, int'(ROWS[i].r[1:0]) + 1);
		end
		i_enhanced = 1'b1;
		cyc(20'h1_0000, 1'b1, 6'h3F, 3'h5, 2);
		cyc(20'h1_4000, 1'b1, 6'h3D, 3'h5, 2);
		i_enhanced = 1'b0;
		wr(`CSD_OFF_MSIZE, 16'h0100);
		cyc(20'h1_0800, 1'b1, 6'h3B, 3'h5, 2);
		cyc(20'h1_2000, 1'b1, 6'h3F, 3'h0, 1);
		slow = 4'h6;
		cyc(20'h0_0000, 1'b1, 6'h2F, 3'h4, 1);
		wr(`CSD_OFF_LOWER, 16'h0078);
		cyc(20'h0_0000, 1'b1, 6'h2F, 3'h0, 0);
		chk("slow", 16'h0001, 16'(last_n > 7 && last_n < 14));
		slow = 4'h0;
		i_rst_n = 1'b0;
		i_cyc = '{valid: 1'b1, start: 1'b0, mem: 1'b1, addr: 20'h0_0000};
		repeat (3) begin
			@(posedge i_clk_sys) #1;
			chk("sel", 16'h003F, 16'(sel));
		end
		i_cyc.valid = 1'b0;
		i_rst_n = 1'b1;
		@(posedge i_clk_sys) #1;
		cyc(20'h0_0000, 1'b1, 6'h3F, 3'h0, 1);
		rd(`CSD_OFF_LOWER, 16'h0000);
		cyc(20'h0_0000, 1'b1, 6'h2F, 3'h0, 1);
		test_done();
	end
endmodule
`default_nettype wire

// ===== tb/csd_mem_model.sv
// Memory device model that drives external ready back to the decoder.
`timescale 1ns/100ps
`default_nettype none
module csd_mem_model (
	input  wire logic       i_clk_sys,
	input  wire logic [5:0] i_sel_n,
	input  wire logic [3:0] i_slow,
	output logic            o_ready
);
	logic [3:0] cnt_q = 4'h0;
	logic       hit_q = 1'b0;
	wire        hit   = ~&i_sel_n;
	always_ff @(posedge i_clk_sys) begin
		hit_q <= hit;
		if (hit && !hit_q) begin
			cnt_q <= i_slow;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	// A slow device holds ready low until its access time has run out.
	assign o_ready = (i_slow == 4'h0) || (hit && hit_q && cnt_q == 4'h0);
endmodule
`default_nettype wire
